// *** core/bfc_fast_charge.sv ***
// Fast-charge control: conditions, ready event, enable, current limit,
// USB throttling and thermal pause. Analogue sense inputs are async pins.
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
module bfc_fast_charge #(
  parameter int unsigned TEMP_HOLD_CYC =
    bfc_pkg::TEMP_HOLD_S * bfc_pkg::CLK_HZ  // 8 s of clock
) (
  input  wire logic              clk,          // 10 MHz clock
  input  wire logic              rst,          // Async reset, high
  input  wire logic [7:0]        reg_addr,     // Register address
  input  wire logic [15:0]       reg_wdata,    // Write data
  input  wire logic              reg_wr,       // Write strobe
  input  wire logic              reg_rd,       // Read strobe
  output logic      [15:0]       reg_rdata,    // Read data, next cycle
  input  wire bfc_pkg::bfc_sense_t sense,      // Async analogue status
  input  wire logic              charge_ena,   // Trickle charge allowed
  output logic      [3:0]        current_set,  // Current code to path
  output logic                   charging,     // Charge current on
  output logic                   eoc_suppress, // Mask end-of-charge
  output logic                   timer_reload  // Reload charge timer
);
  bfc_pkg::bfc_sense_t s1_q, s2_q;
  logic       ce1_q, ce2_q;
  logic       cond, cond_q;
  logic       ready_evt_q, fast_en_q, thr_en_q, hold_q, key_q;
  logic [3:0] isel_q, cur_q;
  logic [1:0] thr_t_q;
  logic [3:0] tinit_q;
  logic       term_q, hot_hold;
  logic [31:0] hot_cnt_q;
  logic [15:0] step_cnt_q, step_len;
  logic       rd_ready, wr_one, wr_two, wr_three;
  bfc_pkg::bfc_state_t state_q;

  // Two-stage synchroniser for every analogue pin
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q  <= '0;
      s2_q  <= '0;
      ce1_q <= 1'b0;
      ce2_q <= 1'b0;
    end
    else
    begin
      s1_q  <= sense;
      s2_q  <= s1_q;
      ce1_q <= charge_ena;
      ce2_q <= ce1_q;
    end
  end

  // Conditions satisfied signal
  assign cond = s2_q.active & s2_q.src_ok & s2_q.vsrc_ok & s2_q.vbat_ok
                & ~s2_q.vbat_low;

  // Decoded strobes; writes need the key except the key register itself
  assign rd_ready = reg_rd && (reg_addr == bfc_pkg::ADDR_INT_STATUS);
  assign wr_one   = reg_wr && key_q && (reg_addr == bfc_pkg::ADDR_CTRL_ONE);
  assign wr_two   = reg_wr && key_q && (reg_addr == bfc_pkg::ADDR_CTRL_TWO);
  assign wr_three = reg_wr && key_q
                    && (reg_addr == bfc_pkg::ADDR_CTRL_THREE);

  // Security key: exact unlock value opens, any other value written to the key locks
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      key_q <= 1'b0;
    else if (reg_wr && reg_addr == bfc_pkg::ADDR_KEY)
      key_q <= (reg_wdata == bfc_pkg::KEY_UNLOCK);
  end

  // Ready event: edge of conditions; a new edge wins over the read clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cond_q      <= 1'b0;
      ready_evt_q <= 1'b0;
    end
    else
    begin
      cond_q <= cond;
      if (cond && !cond_q)
        ready_evt_q <= 1'b1;
      else if (rd_ready)
        ready_evt_q <= 1'b0;
    end
  end

  // Enable bit: forced low without conditions; only the host sets it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      fast_en_q <= 1'b0;
    else if (!cond)
      fast_en_q <= 1'b0;
    else if (wr_one)
      fast_en_q <= reg_wdata[bfc_pkg::BIT_FAST_EN];
  end

  // Timer reload pulse when a host write flips the enable bit; a forced
  // clear on lapse keeps the count, since a fall back to trickle must not
  // restart the timer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      timer_reload <= 1'b0;
    else
      timer_reload <= wr_one && cond
                      && (reg_wdata[bfc_pkg::BIT_FAST_EN]
                          != fast_en_q);
  end

  // Control fields behind the key
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      thr_en_q <= 1'b0;
      hold_q   <= 1'b0;
      isel_q   <= bfc_pkg::ISEL_RESET;
      thr_t_q  <= bfc_pkg::THR_T_RESET;
      tinit_q  <= bfc_pkg::TIMER_INIT_RESET;
    end
    else
    begin
      if (wr_one)
        thr_en_q <= reg_wdata[bfc_pkg::BIT_THROTTLE_EN];
      if (wr_two)
      begin
        hold_q  <= reg_wdata[bfc_pkg::BIT_HOLD];
        isel_q  <= reg_wdata[bfc_pkg::ISEL_LSB +: 4];
        tinit_q <= reg_wdata[bfc_pkg::TIME_LSB +: 4];
      end
      if (wr_three)
        thr_t_q <= reg_wdata[bfc_pkg::THR_LSB +: 2];
    end
  end

  // Charger mode; never moves to fast on its own
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state_q <= bfc_pkg::BFC_OFF;
    else
    begin
      case (state_q)
        bfc_pkg::BFC_OFF:
          if (ce2_q && !term_q)
            state_q <= bfc_pkg::BFC_TRICKLE;
        bfc_pkg::BFC_TRICKLE:
          if (!ce2_q || term_q)
            state_q <= bfc_pkg::BFC_OFF;
          else if (fast_en_q && cond)
            state_q <= bfc_pkg::BFC_FAST;
        bfc_pkg::BFC_FAST:
          if (!ce2_q || term_q)
            state_q <= bfc_pkg::BFC_OFF;
          else if (!cond || !fast_en_q)
            state_q <= bfc_pkg::BFC_TRICKLE;
        default:
          state_q <= bfc_pkg::BFC_OFF;
      endcase
    end
  end

  // USB limit without throttling ends charging until fast enable drops
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      term_q <= 1'b0;
    else if (!fast_en_q)
      term_q <= 1'b0;
    else if (state_q == bfc_pkg::BFC_FAST && s2_q.usb_limit && !thr_en_q)
      term_q <= 1'b1;
  end

  // Thermal pause: while hot in fast mode, then 8 s after the die cools; always on
  // Re-armed on every hot cycle in fast mode, so the 8 s run from the last such cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      hot_cnt_q <= '0;
    else if (s2_q.hot && state_q == bfc_pkg::BFC_FAST)
      hot_cnt_q <= TEMP_HOLD_CYC;
    else if (hot_cnt_q != '0)
      hot_cnt_q <= hot_cnt_q - 32'h1;
  end
  assign hot_hold = (hot_cnt_q != '0);

  // Step interval chosen by the step-time field
  always_comb
  begin
    case (thr_t_q)
      2'h0:    step_len = 16'(bfc_pkg::STEP_US_0 * bfc_pkg::CYC_PER_US);
      2'h1:    step_len = 16'(bfc_pkg::STEP_US_1 * bfc_pkg::CYC_PER_US);
      2'h2:    step_len = 16'(bfc_pkg::STEP_US_2 * bfc_pkg::CYC_PER_US);
      default: step_len = 16'(bfc_pkg::STEP_US_3 * bfc_pkg::CYC_PER_US);
    endcase
  end

  // Throttle: step down on USB limit, step back up towards the limit
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cur_q      <= bfc_pkg::ISEL_OFF;
      step_cnt_q <= '0;
    end
    else if (state_q != bfc_pkg::BFC_FAST)
    begin
      cur_q      <= isel_q;
      step_cnt_q <= '0;
    end
    else if (cur_q > isel_q)
      cur_q <= isel_q;
    else if (step_cnt_q + 16'h1 < step_len)
      step_cnt_q <= step_cnt_q + 16'h1;
    else
    begin
      step_cnt_q <= '0;
      if (thr_en_q && s2_q.usb_limit && cur_q != bfc_pkg::ISEL_OFF)
        cur_q <= cur_q - 4'h1;
      else if (!s2_q.usb_limit && cur_q < isel_q)
        cur_q <= cur_q + 4'h1;
    end
  end

  // Analogue drive; trickle current itself is set elsewhere
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      current_set  <= bfc_pkg::ISEL_OFF;
      charging     <= 1'b0;
      eoc_suppress <= 1'b0;
    end
    else
    begin
      current_set  <= (state_q == bfc_pkg::BFC_FAST) ? cur_q
                      : bfc_pkg::ISEL_OFF;
      charging     <= (state_q != bfc_pkg::BFC_OFF) && !hold_q
                      && !hot_hold;
      eoc_suppress <= thr_en_q;
    end
  end

  // Read port, data valid in the cycle after the strobe
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= '0;
    else if (reg_rd)
    begin
      reg_rdata <= '0;
      case (reg_addr)
        bfc_pkg::ADDR_INT_STATUS:
          reg_rdata[bfc_pkg::BIT_FAST_READY] <= ready_evt_q;
        bfc_pkg::ADDR_CTRL_ONE:
        begin
          reg_rdata[bfc_pkg::BIT_FAST_EN]     <= fast_en_q;
          reg_rdata[bfc_pkg::BIT_THROTTLE_EN] <= thr_en_q;
        end
        bfc_pkg::ADDR_CTRL_TWO:
        begin
          reg_rdata[bfc_pkg::BIT_HOLD]          <= hold_q;
          reg_rdata[bfc_pkg::STS_LSB +: 2]      <=
            (state_q == bfc_pkg::BFC_FAST)    ? bfc_pkg::STS_FAST :
            (state_q == bfc_pkg::BFC_TRICKLE) ? bfc_pkg::STS_TRICKLE :
                                                bfc_pkg::STS_OFF;
          reg_rdata[bfc_pkg::TIME_LSB +: 4]     <= tinit_q;
          reg_rdata[bfc_pkg::ISEL_LSB +: 4]     <= isel_q;
        end
        bfc_pkg::ADDR_CTRL_THREE:
          reg_rdata[bfc_pkg::THR_LSB +: 2] <= thr_t_q;
        bfc_pkg::ADDR_KEY:
          reg_rdata[bfc_pkg::KEY_BIT] <= key_q;
        default:
          reg_rdata <= '0;
      endcase
    end
    else
      reg_rdata <= '0;
  end

  // Checks: enable bit and mode entry
  enable_from_host_a: assert property (
    @(posedge clk) disable iff (rst)
    $rose(fast_en_q) |-> $past(wr_one) && $past(cond))
    else $error("enable bit set without host write and conditions");
  enable_held_low_a: assert property (
    @(posedge clk) disable iff (rst)
    !cond |=> !fast_en_q)
    else $error("enable bit not held low without conditions");
  fast_needs_enable_a: assert property (
    @(posedge clk) disable iff (rst)
    (state_q == bfc_pkg::BFC_FAST && $past(state_q) != bfc_pkg::BFC_FAST)
    |-> $past(fast_en_q) && $past(cond))
    else $error("fast entered without enable and conditions");
  // Ready event: a fresh edge sets it, a read alone clears it
  ready_edge_a: assert property (
    @(posedge clk) disable iff (rst)
    (cond && !cond_q) |=> ready_evt_q)
    else $error("ready event not raised on edge");
  ready_clear_a: assert property (
    @(posedge clk) disable iff (rst)
    (rd_ready && !(cond && !cond_q)) |=> !ready_evt_q)
    else $error("ready event not cleared by read");
  ready_fresh_a: assert property (
    @(posedge clk) disable iff (rst)
    (!ready_evt_q && !(cond && !cond_q)) |=> !ready_evt_q)
    else $error("ready event raised without a fresh edge");
  // Current path; the code out lags the limit by two registers
  current_limit_a: assert property (
    @(posedge clk) disable iff (rst)
    current_set <= $past(isel_q, 2))
    else $error("current above programmed limit");
  hot_pause_a: assert property (
    @(posedge clk) disable iff (rst)
    (s2_q.hot && state_q == bfc_pkg::BFC_FAST) |=> ##1 !charging[*8])
    else $error("charging not paused when hot");
  hold_stops_a: assert property (
    @(posedge clk) disable iff (rst)
    hold_q |=> !charging)
    else $error("charging while held");
  lapse_trickle_a: assert property (
    @(posedge clk) disable iff (rst)
    (state_q == bfc_pkg::BFC_FAST && !cond && ce2_q && !term_q)
    |=> state_q == bfc_pkg::BFC_TRICKLE)
    else $error("no fall back to trickle");
  low_battery_a: assert property (
    @(posedge clk) disable iff (rst)
    (state_q == bfc_pkg::BFC_FAST && s2_q.vbat_low && ce2_q && !term_q)
    |=> state_q == bfc_pkg::BFC_TRICKLE)
    else $error("no fall back to trickle on low battery");
  // USB limit handling
  usb_terminate_a: assert property (
    @(posedge clk) disable iff (rst)
    (state_q == bfc_pkg::BFC_FAST && fast_en_q && s2_q.usb_limit
     && !thr_en_q) |=> ##1 state_q == bfc_pkg::BFC_OFF)
    else $error("charging not ended at USB limit");
  throttle_keeps_a: assert property (
    @(posedge clk) disable iff (rst)
    (state_q == bfc_pkg::BFC_FAST && thr_en_q && !term_q)
    |=> !term_q)
    else $error("throttled charge was terminated");
  eoc_mask_a: assert property (
    @(posedge clk) disable iff (rst)
    thr_en_q |=> eoc_suppress)
    else $error("end of charge not masked while throttling");
  // Register side
  locked_write_a: assert property (
    @(posedge clk) disable iff (rst)
    (reg_wr && !key_q && reg_addr == bfc_pkg::ADDR_CTRL_TWO)
    |=> $stable(isel_q))
    else $error("locked write changed limit");
  state_field_a: assert property (
    @(posedge clk) disable iff (rst)
    (reg_rd && reg_addr == bfc_pkg::ADDR_CTRL_TWO
     && state_q == bfc_pkg::BFC_FAST)
    |=> reg_rdata[bfc_pkg::STS_LSB +: 2] == bfc_pkg::STS_FAST)
    else $error("state field does not show fast mode");
endmodule : bfc_fast_charge

// *** core/bfc_pkg.sv ***
// Package for the fast-charge control block: register map, fields, timing.
// Assumes a 10 MHz system clock and a 16-bit register port.
package bfc_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h15;
  localparam logic [7:0] ADDR_CTRL_ONE   = 8'hA8;
  localparam logic [7:0] ADDR_CTRL_TWO   = 8'hA9;
  localparam logic [7:0] ADDR_CTRL_THREE = 8'hAA;
  localparam logic [7:0] ADDR_KEY        = 8'hAB;
  localparam logic [15:0] KEY_UNLOCK     = 16'h9A5C;
  localparam int BIT_FAST_READY  = 9;
  localparam int BIT_FAST_EN     = 5;
  localparam int BIT_THROTTLE_EN = 4;
  localparam int BIT_HOLD        = 14;
  localparam int STS_LSB         = 12;
  localparam int THR_LSB         = 5;
  localparam int ISEL_LSB        = 0;
  localparam int KEY_BIT         = 0;
  localparam logic [1:0] THR_T_RESET = 2'h0;
  localparam logic [3:0] ISEL_RESET = 4'h6;
  localparam logic [3:0] ISEL_OFF   = 4'h0;
  localparam logic [3:0] TIMER_INIT_RESET = 4'hB;
  localparam int TIME_LSB = 8;
  localparam int unsigned TEMP_HOLD_S = 8;
  localparam int unsigned STEP_US_0 = 8;
  localparam int unsigned STEP_US_1 = 16;
  localparam int unsigned STEP_US_2 = 32;
  localparam int unsigned STEP_US_3 = 128;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  localparam logic [1:0] STS_OFF     = 2'h0;
  localparam logic [1:0] STS_TRICKLE = 2'h1;
  localparam logic [1:0] STS_FAST    = 2'h2;
  typedef enum logic [1:0] {BFC_OFF, BFC_TRICKLE, BFC_FAST} bfc_state_t;
  typedef struct packed {
    logic active;     // Active power state
    logic src_ok;     // Wall selected or USB high power
    logic vsrc_ok;    // Source voltage suitable
    logic vbat_ok;    // Battery above 3.1V
    logic vbat_low;   // Low battery detected
    logic hot;        // Die above 115 C
    logic usb_limit;  // USB current limit reached
  } bfc_sense_t;
endpackage : bfc_pkg

// *** verification/bfc_path_model.sv ***
// Model of the analogue charge path's USB rail limit beside the block.
// Assumes the bench sets the highest code the USB rail can carry.
`timescale 1ns/100ps
module bfc_path_model (
  input  wire logic       clk,         // System clock
  input  wire logic       charging,    // Charge current on
  input  wire logic [3:0] current_set, // Requested current code
  input  wire logic [3:0] usb_cap,     // Highest code the rail holds
  output logic            usb_limit    // Rail at its current limit
);
  // Starts quiet so the block never sees an unknown sense bit
  initial usb_limit = 1'b0;
  // A cycle late, like a slow comparator on the rail
  always @(posedge clk)
    usb_limit <= charging && (current_set > usb_cap);
endmodule : bfc_path_model

// *** verification/bfc_fast_charge_tb_top.sv ***
// Bench for the fast-charge control block, checked against a model.
// Assumes a 10 MHz clock and the register map of the package.
`timescale 1ns/100ps
module bfc_fast_charge_tb_top;
  localparam logic [7:0] A_INT = bfc_pkg::ADDR_INT_STATUS;
  localparam logic [7:0] A_ONE = bfc_pkg::ADDR_CTRL_ONE;
  localparam logic [7:0] A_TWO = bfc_pkg::ADDR_CTRL_TWO;
  localparam logic [7:0] A_THR = bfc_pkg::ADDR_CTRL_THREE;
  logic                clk          = 1'b0;
  logic                rst          = 1'b1;
  logic [7:0]          reg_addr     = 8'h00;
  logic [15:0]         reg_wdata    = 16'h0000;
  logic                reg_wr       = 1'b0;
  logic                reg_rd       = 1'b0;
  logic [5:0]          cond         = 6'h00;
  logic                charge_ena   = 1'b0;
  logic [3:0]          usb_cap      = 4'hF;
  logic [15:0]         reg_rdata;
  bfc_pkg::bfc_sense_t sense;
  logic [3:0]          current_set;
  logic                charging;
  logic                eoc_suppress;
  logic                timer_reload;
  logic                usb_limit;
  int                  bad_count    = 0;
  int                  compares     = 0;
  int                  reloads      = 0;
  // Reference model of the register fields and charger state
  logic [3:0]          m_lim        = bfc_pkg::ISEL_RESET;
  logic [3:0]          m_tim        = bfc_pkg::TIMER_INIT_RESET;
  logic                m_hold       = 1'b0;
  logic                m_fast       = 1'b0;
  logic                m_thr        = 1'b0;
  logic [1:0]          m_step       = 2'h0;
  logic [1:0]          m_st         = bfc_pkg::STS_OFF;

  // Sense bits: active, source, voltage, battery, low, hot; then rail
  assign sense = {cond, usb_limit};

  bfc_fast_charge #(.TEMP_HOLD_CYC(100)) bfc_fast_charge_i (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sense(sense), .charge_ena(charge_ena), .current_set(current_set),
    .charging(charging), .eoc_suppress(eoc_suppress),
    .timer_reload(timer_reload));

  bfc_path_model bfc_path_model_i (.clk(clk), .charging(charging),
    .current_set(current_set), .usb_cap(usb_cap), .usb_limit(usb_limit));

  // 100 ns period
  always #50 clk = ~clk;

  // Counts timer reload pulses; each one must stand alone
  always @(posedge clk)
    if (timer_reload === 1'b1)
      reloads <= reloads + 1;

  task automatic chk(input string what, input logic [15:0] e, g);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic chk_out(input logic ch, input logic [3:0] cur);
    chk("charging", {15'h0, ch}, {15'h0, charging});
    chk("current_set", {12'h0, cur}, {12'h0, current_set});
  endtask : chk_out

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [15:0] m, e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 chk("reg_rdata", e & m, reg_rdata & m);
  endtask : rd

  task automatic rd8();
    rd(A_ONE, 16'h0030, {10'h0, m_fast, m_thr, 4'h0});
  endtask : rd8

  task automatic rd9();
    rd(A_TWO, 16'h7F0F, {1'b0, m_hold, m_st, m_tim, 4'h0, m_lim});
  endtask : rd9

  task automatic wr9();
    wr(A_TWO, {1'b0, m_hold, 2'h0, m_tim, 4'h0, m_lim});
  endtask : wr9

  // Lets synchronisers and registers catch up before sampling
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic conclude();
    if (bad_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  // Cuts a hung run short
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    conclude();
  end

  // Main sequence
  initial
  begin
    int n;
    n = $urandom(32'h71BC);
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd8();
    rd9();
    rd(A_THR, 16'h0060, 16'h0000);
    rd(8'h30, 16'hFFFF, 16'h0000);
    // Locked writes must not land
    wr(A_TWO, 16'h0003);
    rd9();
    wr(bfc_pkg::ADDR_KEY, bfc_pkg::KEY_UNLOCK);
    @(posedge clk) charge_ena <= 1'b1;
    wr(A_ONE, 16'h0020);
    settle(6);
    rd8();
    chk("current_set", 16'h0, {12'h0, current_set});
    // Conditions met: one event, cleared by its read
    @(posedge clk) cond <= 6'h3C;
    settle(6);
    rd(A_INT, 16'h0200, 16'h0200);
    rd(A_INT, 16'h0200, 16'h0000);
    m_st = bfc_pkg::STS_TRICKLE;
    rd9();
    n = reloads;
    wr(A_ONE, 16'h0020);
    settle(6);
    m_fast = 1'b1;
    m_st   = bfc_pkg::STS_FAST;
    chk("reloads", 16'(n + 1), 16'(reloads));
    rd8();
    rd9();
    chk_out(1'b1, m_lim);
    // Limits kept at or under 400mA as on a USB rail
    repeat (4)
    begin
      m_lim = 4'($urandom_range(8, 1));
      wr9();
      // A higher limit is reached one code per 8 us step
      settle(700);
      chk_out(1'b1, m_lim);
    end
    m_hold = 1'b1;
    wr9();
    settle(6);
    chk("charging", 16'h0, {15'h0, charging});
    rd9();
    m_hold = 1'b0;
    wr9();
    settle(6);
    chk_out(1'b1, m_lim);
    // Short hot spell still pauses for the full hold
    @(posedge clk) cond <= 6'h3D;
    settle(20);
    @(posedge clk) cond <= 6'h3C;
    settle(60);
    chk("charging", 16'h0, {15'h0, charging});
    settle(60);
    chk("charging", 16'h1, {15'h0, charging});
    for (int s = 3; s >= 0; s--)
    begin
      m_step = 2'(s);
      wr(A_THR, {9'h0, m_step, 5'h0});
      rd(A_THR, 16'h0060, {9'h0, m_step, 5'h0});
    end
    // Throttle first, so the rail limit terminates charging only once throttling is cleared
    m_lim = 4'h5;
    wr9();
    m_thr = 1'b1;
    wr(A_ONE, 16'h0030);
    @(posedge clk) usb_cap <= 4'h3;
    settle(600);
    chk("eoc_suppress", 16'h1, {15'h0, eoc_suppress});
    chk("charging", 16'h1, {15'h0, charging});
    chk("band", 16'h1, {15'h0, (current_set inside {4'h3, 4'h4})});
    m_thr = 1'b0;
    wr(A_ONE, 16'h0020);
    settle(300);
    chk("eoc_suppress", 16'h0, {15'h0, eoc_suppress});
    chk("charging", 16'h0, {15'h0, charging});
    // Active state lost: back to trickle
    @(posedge clk) cond <= 6'h1C;
    settle(6);
    m_fast = 1'b0;
    m_st   = bfc_pkg::STS_TRICKLE;
    rd8();
    rd9();
    chk("current_set", 16'h0, {12'h0, current_set});
    @(posedge clk) usb_cap <= 4'hF;
    @(posedge clk) cond <= 6'h3C;
    settle(6);
    rd(A_INT, 16'h0200, 16'h0200);
    wr(A_ONE, 16'h0020);
    settle(6);
    chk_out(1'b1, m_lim);
    @(posedge clk) cond <= 6'h3E;
    settle(6);
    m_fast = 1'b0;
    rd9();
    chk("current_set", 16'h0, {12'h0, current_set});
    // Two host sets reload the timer; forced clears on lapse do not
    chk("reloads", 16'(n + 2), 16'(reloads));
    conclude();
  end
endmodule : bfc_fast_charge_tb_top
